// *** hw/swbm_pkg.sv ***
// Package for the single-wire bus master: timing figures and states.
// Assumes a 25 MHz module clock; every count is derived from it.
package swbm_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int CYC_PER_US = CLK_HZ / 1000000;
	// Times in microseconds, as specified
	localparam int RESET_LOW_US = 511;
	localparam int RESET_RECOVERY_US = 512;
	localparam int ZERO_LOW_US = 100;
	localparam int ONE_LOW_US = 5;
	localparam int SLOT_US = 117;
	localparam int SAMPLE_US = 13;
	localparam int PRES_WAIT_MIN_US = 15;
	localparam int PRES_LOW_MAX_US = 240;
	// Cycle counts
	localparam int RESET_LOW_CYC = RESET_LOW_US * CYC_PER_US;
	localparam int RESET_RECOVERY_CYC = RESET_RECOVERY_US * CYC_PER_US;
	localparam int ZERO_LOW_CYC = ZERO_LOW_US * CYC_PER_US;
	localparam int ONE_LOW_CYC = ONE_LOW_US * CYC_PER_US;
	localparam int SLOT_CYC = SLOT_US * CYC_PER_US;
	localparam int SAMPLE_CYC = SAMPLE_US * CYC_PER_US;
	localparam int PRES_FROM_CYC = PRES_WAIT_MIN_US * CYC_PER_US;
	localparam int PRES_TO_CYC = (60 + PRES_LOW_MAX_US) * CYC_PER_US;
	localparam int CNT_W = 14;
	// Command codes
	localparam logic [1:0] CMD_RESET = 2'h0;
	localparam logic [1:0] CMD_WRITE0 = 2'h1;
	localparam logic [1:0] CMD_WRITE1 = 2'h2;
	localparam logic [1:0] CMD_READ = 2'h3;
	typedef enum logic [1:0] {
		SWBM_IDLE = 2'b00,
		SWBM_LOW  = 2'b01,
		SWBM_HIGH = 2'b10
	} swbm_state_t;
endpackage

// *** hw/swbm_master.sv ***
// Single-wire bus master: reset/presence sequence and bit time slots.
// Assumes an external pull-up on the line and a command source that
// honours valid/ready; results leave through a two-entry buffer.
`timescale 1ns/100ps
module swbm_master
	import swbm_pkg::*;
#(
	parameter int RESET_LOW_CYCLES = RESET_LOW_CYC,
	parameter int RESET_REC_CYCLES = RESET_RECOVERY_CYC
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             cmd_valid_i,
	input  wire logic [1:0]       cmd_code_i,
	output logic                  cmd_ready_o,
	output logic                  res_valid_o,
	output logic                  res_data_o,
	output logic                  res_is_presence_o,
	input  wire logic             res_ready_i,
	output logic                  presence_o,
	output logic                  busy_o,
	input  wire logic             line_i,
	output logic                  line_o,
	output logic                  line_oe_o
);
	import swbm_pkg::*;

	swbm_state_t    state_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [1:0]     cmd_ff;
	logic           sync1_ff;
	logic           sync2_ff;
	logic           seen_low_ff;
	logic           bit_ff;
	logic [1:0]     buf_data_ff [0:1];
	logic [1:0]     buf_cnt_ff;
	logic           wr_ptr_ff;
	logic           rd_ptr_ff;
	logic           low_end;
	logic           high_end;
	logic           push;
	logic           pop;
	logic           buf_full;
	logic [CNT_W-1:0] low_run_ff;
	logic [CNT_W-1:0] slot_run_ff;

	// Low phase length for a command
	function automatic logic [CNT_W-1:0] low_len(input logic [1:0] c);
		unique case (c)
			CMD_RESET:  low_len = CNT_W'(RESET_LOW_CYCLES - 1);
			CMD_WRITE0: low_len = CNT_W'(ZERO_LOW_CYC - 1);
			default:    low_len = CNT_W'(ONE_LOW_CYC - 1);
		endcase
	endfunction

	// Released phase length; slot counted from falling edge
	function automatic logic [CNT_W-1:0] high_len(input logic [1:0] c);
		unique case (c)
			CMD_RESET:  high_len = CNT_W'(RESET_REC_CYCLES - 1);
			CMD_WRITE0: high_len = CNT_W'(SLOT_CYC - ZERO_LOW_CYC - 1);
			default:    high_len = CNT_W'(SLOT_CYC - ONE_LOW_CYC - 1);
		endcase
	endfunction

	assign buf_full = (buf_cnt_ff == 2'h2);
	assign low_end = (state_ff == SWBM_LOW) && (cnt_ff == low_len(cmd_ff));
	assign high_end = (state_ff == SWBM_HIGH) && (cnt_ff == high_len(cmd_ff));
	assign push = high_end && (cmd_ff == CMD_RESET || cmd_ff == CMD_READ);
	assign pop = res_valid_o && res_ready_i;

	// Line input synchroniser
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
		end else begin
			sync1_ff <= line_i;
			sync2_ff <= sync1_ff;
		end
	end

	// Slot sequencer; a new command waits for buffer room
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_ff <= SWBM_IDLE;
			cnt_ff <= '0;
			cmd_ff <= CMD_RESET;
		end else begin
			unique case (state_ff)
				SWBM_IDLE: begin
					if (cmd_valid_i && !buf_full) begin
						state_ff <= SWBM_LOW;
						cmd_ff <= cmd_code_i;
						cnt_ff <= '0;
					end
				end
				SWBM_LOW: begin
					if (low_end) begin
						state_ff <= SWBM_HIGH;
					end
					cnt_ff <= low_end ? '0 : cnt_ff + 1'b1;
				end
				SWBM_HIGH: begin
					if (high_end) begin
						state_ff <= SWBM_IDLE;
					end
					cnt_ff <= high_end ? '0 : cnt_ff + 1'b1;
				end
				default: state_ff <= SWBM_IDLE;
			endcase
		end
	end

	// Line drive and handshake outputs
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			line_oe_o <= 1'b0;
			line_o <= 1'b0;
			cmd_ready_o <= 1'b0;
			busy_o <= 1'b0;
		end else begin
			line_o <= 1'b0;
			line_oe_o <= (state_ff == SWBM_IDLE && cmd_valid_i && !buf_full)
				|| (state_ff == SWBM_LOW && !low_end);
			cmd_ready_o <= 1'b0;
			if (state_ff == SWBM_IDLE && cmd_valid_i && !buf_full
				&& !cmd_ready_o) begin
				cmd_ready_o <= 1'b1;
			end
			busy_o <= (state_ff != SWBM_IDLE) || (cmd_valid_i && !buf_full);
		end
	end

	// Presence window watch and read sample
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			seen_low_ff <= 1'b0;
			bit_ff <= 1'b1;
		end else begin
			if (state_ff == SWBM_IDLE) begin
				seen_low_ff <= 1'b0;
			end else if (state_ff == SWBM_HIGH && cmd_ff == CMD_RESET
				&& cnt_ff >= CNT_W'(PRES_FROM_CYC)
				&& cnt_ff <= CNT_W'(PRES_TO_CYC) && !sync2_ff) begin
				seen_low_ff <= 1'b1;
			end
			if (state_ff == SWBM_HIGH && cmd_ff == CMD_READ
				&& cnt_ff == CNT_W'(SAMPLE_CYC - ONE_LOW_CYC)) begin
				bit_ff <= sync2_ff;
			end
		end
	end

	// Two-entry result buffer: {is_presence, data}
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			buf_data_ff[0] <= 2'h0;
			buf_data_ff[1] <= 2'h0;
			buf_cnt_ff <= 2'h0;
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
		end else begin
			if (push) begin
				buf_data_ff[wr_ptr_ff] <= (cmd_ff == CMD_RESET) ?
					{1'b1, seen_low_ff} : {1'b0, bit_ff};
				wr_ptr_ff <= ~wr_ptr_ff;
			end
			if (pop) begin
				rd_ptr_ff <= ~rd_ptr_ff;
			end
			buf_cnt_ff <= buf_cnt_ff + {1'b0, push} - {1'b0, pop};
		end
	end

	// Registered buffer head and presence flag
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			res_valid_o <= 1'b0;
			res_data_o <= 1'b0;
			res_is_presence_o <= 1'b0;
			presence_o <= 1'b0;
		end else begin
			if (!res_valid_o || pop) begin
				if (buf_cnt_ff - {1'b0, pop} != 2'h0) begin
					res_valid_o <= 1'b1;
					{res_is_presence_o, res_data_o} <=
						buf_data_ff[rd_ptr_ff ^ pop];
				end else begin
					res_valid_o <= 1'b0;
				end
			end
			if (push && cmd_ff == CMD_RESET) begin
				presence_o <= seen_low_ff;
			end
		end
	end

	// Drive length and slot age, counted apart from the sequencer count;
	// slot age wraps in long reset slots, which are not judged on it
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			low_run_ff <= '0;
			slot_run_ff <= '0;
		end else begin
			low_run_ff <= line_oe_o ? low_run_ff + 1'b1 : '0;
			slot_run_ff <= (state_ff == SWBM_IDLE) ? '0 : slot_run_ff + 1'b1;
		end
	end

	// Reset low pulse lasts the full count
	property p_reset_low;
		@(posedge clk_i) disable iff (!rst_n_i)
		$fell(line_oe_o) && cmd_ff == CMD_RESET
			|-> low_run_ff == CNT_W'(RESET_LOW_CYCLES);
	endproperty
	a_reset_low: assert property (p_reset_low)
		else $error("reset low pulse cut short");

	// After reset release the line stays released
	property p_recovery;
		@(posedge clk_i) disable iff (!rst_n_i)
		(state_ff == SWBM_HIGH && cmd_ff == CMD_RESET) |=> !line_oe_o;
	endproperty
	a_recovery: assert property (p_recovery)
		else $error("line driven during reset recovery");

	// Zero bit low phase lasts its count
	property p_zero_low;
		@(posedge clk_i) disable iff (!rst_n_i)
		$fell(line_oe_o) && cmd_ff == CMD_WRITE0
			|-> low_run_ff == CNT_W'(ZERO_LOW_CYC);
	endproperty
	a_zero_low: assert property (p_zero_low)
		else $error("zero bit low length wrong");

	// One or read low phase ends on time and releases
	property p_one_low;
		@(posedge clk_i) disable iff (!rst_n_i)
		$fell(line_oe_o) && cmd_ff[1]
			|-> low_run_ff == CNT_W'(ONE_LOW_CYC);
	endproperty
	a_one_low: assert property (p_one_low)
		else $error("one/read low not released");

	// Slot ends at the slot count
	property p_slot;
		@(posedge clk_i) disable iff (!rst_n_i)
		high_end && cmd_ff != CMD_RESET |-> slot_run_ff == CNT_W'(SLOT_CYC - 1);
	endproperty
	a_slot: assert property (p_slot)
		else $error("slot length wrong");

	// Zero slot end within limit
	property p_zero_slot;
		@(posedge clk_i) disable iff (!rst_n_i)
		high_end && cmd_ff == CMD_WRITE0 |-> state_ff == SWBM_HIGH ##1
			state_ff == SWBM_IDLE;
	endproperty
	a_zero_slot: assert property (p_zero_slot)
		else $error("zero slot did not end");

	// A pushed read result shows as valid one to four cycles later
	property p_read;
		@(posedge clk_i) disable iff (!rst_n_i)
		push && cmd_ff == CMD_READ && !buf_full |=> ##[0:3] res_valid_o;
	endproperty
	a_read: assert property (p_read)
		else $error("read result not delivered");

	// Presence flag follows the window watch
	property p_presence;
		@(posedge clk_i) disable iff (!rst_n_i)
		push && cmd_ff == CMD_RESET |=> presence_o == $past(seen_low_ff);
	endproperty
	a_presence: assert property (p_presence)
		else $error("presence flag mismatch");
endmodule

// *** tb/swbm_slave_model.sv ***
// Behavioural slave on the far side of the single-wire line.
// Assumes the line level is given back through an external pull-up.
`timescale 1ns/100ps
module swbm_slave_model #(
	parameter int PRES_WAIT = 375,
	parameter int PRES_LOW  = 1500
) (
	input  wire logic clk_i,
	input  wire logic line_i,
	input  wire logic pres_en_i,
	input  wire logic bit_i,
	output logic      pull_o
);
	logic prev_q = 1'b1;
	logic own_q = 1'b0;
	int   run = 0;
	int   wcnt = 0;
	int   lcnt = 0;
	// Answers reset pulses with presence when pres_en_i is set, any slot with a zero bit when bit_i is low and pres_en_i is clear
	always @(posedge clk_i) begin
		prev_q <= line_i;
		own_q <= pull_o;
		run <= line_i ? 0 : run + 1;
		if (prev_q && !line_i && !pres_en_i && !bit_i)
			lcnt <= 500; // Zero bit answer
		else if (lcnt > 0)
			lcnt <= lcnt - 1;
		if (pres_en_i && line_i && !prev_q && !own_q && run > 300)
			wcnt <= PRES_WAIT;
		else if (wcnt > 1)
			wcnt <= wcnt - 1;
		else if (wcnt == 1) begin
			wcnt <= 0;
			lcnt <= PRES_LOW;
		end
	end
	assign pull_o = (lcnt != 0);
endmodule

// *** tb/test_single_wire_bus_master_timing.sv ***
// Self-checking bench for the single-wire bus master.
// Assumes the master and the slave model share one pulled-up line.
`timescale 1ns/100ps
module test_single_wire_bus_master_timing;
	import swbm_pkg::*;
	localparam int RLOW = 400;
	localparam int RREC = 8000;
	logic       clk_i = 1'b0;
	logic       rst_n_i = 1'b0;
	logic       cmd_valid_i = 1'b0;
	logic [1:0] cmd_code_i = 2'h0;
	logic       res_ready_i = 1'b0;
	logic       pres_en = 1'b0;
	logic       bit_v = 1'b1;
	logic       cmd_ready_o, res_valid_o, res_data_o, res_is_presence_o;
	logic       presence_o, busy_o, line_oe_o, s_pull, line, oe_q;
	logic       drv_lvl;
	int         fail_count = 0;
	int         n_tests = 0;
	int         cyc = 0;
	int         fall_at = 0;
	int         gap = 0;
	int         run = 0;
	int         lowlen = 0;
	logic       got;
	// Open-drain line with pull-up
	assign line = !(line_oe_o | s_pull);
	swbm_master #(.RESET_LOW_CYCLES(RLOW), .RESET_REC_CYCLES(RREC)) dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
		.cmd_code_i(cmd_code_i), .cmd_ready_o(cmd_ready_o),
		.res_valid_o(res_valid_o), .res_data_o(res_data_o),
		.res_is_presence_o(res_is_presence_o), .res_ready_i(res_ready_i),
		.presence_o(presence_o), .busy_o(busy_o), .line_i(line),
		.line_o(drv_lvl), .line_oe_o(line_oe_o));
	swbm_slave_model slave (.clk_i(clk_i), .line_i(line),
		.pres_en_i(pres_en), .bit_i(bit_v), .pull_o(s_pull));
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	// Low-phase length and fall-to-fall spacing
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		oe_q <= line_oe_o;
		if (line_oe_o === 1'b1 && oe_q !== 1'b1) begin
			gap <= cyc - fall_at;
			fall_at <= cyc;
			run <= 1;
		end else if (line_oe_o === 1'b1)
			run <= run + 1;
		else if (oe_q === 1'b1)
			lowlen <= run;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL %0t: seen %0d expected %0d", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cmd(input logic [1:0] c, input int lim);
		int i;
		got = 1'b0;
		@(posedge clk_i);
		#1 cmd_valid_i = 1'b1;
		cmd_code_i = c;
		for (i = 0; i < lim && !got; i++) begin
			@(posedge clk_i);
			#1 got = (cmd_ready_o === 1'b1);
		end
		// Hold the request over the edge that sees ready high
		if (got) begin
			@(posedge clk_i);
			#1;
			chk(busy_o, 1'b1);
			chk(drv_lvl, 1'b0);
		end else if (lim < 1000) begin
			// Short limits expect the command to be taken
			fail_count++;
			end_of_test();
		end
		cmd_valid_i = 1'b0;
		for (i = 0; got && busy_o !== 1'b0; i++) begin
			if (i > 30000) begin
				fail_count++;
				end_of_test();
			end
			@(posedge clk_i);
			#1;
		end
	endtask
	task automatic pop(input logic d, input logic p);
		int i;
		for (i = 0; res_valid_o !== 1'b1; i++) begin
			if (i > 5000) begin
				fail_count++;
				end_of_test();
			end
			@(posedge clk_i);
			#1;
		end
		chk(res_data_o, d);
		chk(res_is_presence_o, p);
		res_ready_i = 1'b1;
		@(posedge clk_i);
		#1 res_ready_i = 1'b0;
		// Let an edge pass before the next request
		@(posedge clk_i);
		#1;
	endtask
	task automatic t_reset;
		pres_en = 1'b1;
		cmd(CMD_RESET, 100);
		chk(lowlen, RLOW);
		pop(1'b1, 1'b1);
		chk(presence_o, 1'b1);
		pres_en = 1'b0;
		cmd(CMD_WRITE1, 100);
		chk(gap >= RLOW + RREC, 1'b1);
		chk(lowlen, ONE_LOW_CYC);
		cmd(CMD_RESET, 100);
		pop(1'b0, 1'b1);
		chk(presence_o, 1'b0);
	endtask
	task automatic t_write;
		cmd(CMD_WRITE0, 100);
		chk(lowlen, ZERO_LOW_CYC);
		cmd(CMD_WRITE0, 100);
		chk(gap > ZERO_LOW_CYC && gap <= 3000, 1'b1);
		cmd(CMD_WRITE1, 100);
		cmd(CMD_WRITE1, 100);
		chk(gap >= 1500 && gap <= 3000, 1'b1);
	endtask
	task automatic t_read;
		bit_v = 1'b0;
		cmd(CMD_READ, 100);
		bit_v = 1'b1;
		cmd(CMD_READ, 100);
		chk(gap >= 1500 && gap <= 3000, 1'b1);
		cmd(CMD_READ, 4000);
		chk(got, 1'b0);
		pop(1'b0, 1'b0);
		pop(1'b1, 1'b0);
		chk(res_valid_o, 1'b0);
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		t_reset();
		t_write();
		t_read();
		end_of_test();
	end
endmodule
